// ---- sbr_pkg.sv ----
// Shared constants and carriers for the bank, row and read burst logic
package sbr_pkg;
	localparam int SBR_NUM_BANKS = 8; // Banks in the device
	localparam int SBR_BA_W = 3; // Width of bank_select_inputs
	localparam int SBR_ROW_W = 14; // Width of row_address_inputs
	localparam int SBR_COL_W = 10; // Column bits taken from the address
	localparam int SBR_AP_BIT = 10; // Auto precharge / precharge-all bit
	localparam int SBR_BC_BIT = 12; // burst_chop_select_bit position
	localparam int SBR_LAT_W = 4; // Width of each latency input
	localparam int SBR_CYC_W = 8; // Link cycle stamp width
	localparam int SBR_TRP_CK = 9; // Default precharge_period in link cycles
	localparam int SBR_TRP_W = 8; // Precharge counter width
	localparam int SBR_FIFO_DEPTH = 4; // Pending read bursts
	localparam logic [3:0] SBR_BEATS_BL8 = 4'h8; // eight_beat_burst
	localparam logic [3:0] SBR_BEATS_BC4 = 4'h4; // four_beat_chopped_burst
	localparam logic [1:0] SBR_MR0_BL8 = 2'h0; // Burst field: fixed eight beats
	localparam logic [1:0] SBR_MR0_OTF = 2'h1; // Burst field: chosen on the fly
	localparam logic [1:0] SBR_MR0_BC4 = 2'h2; // Burst field: fixed chop
	localparam logic [SBR_LAT_W-1:0] SBR_AL_RST = 4'h5; // Reset additive_latency
	localparam logic [SBR_LAT_W-1:0] SBR_CL_RST = 4'h6; // Reset column_access_latency

	// Per-bank state
	typedef enum logic [1:0] {
		SBR_BANK_IDLE,
		SBR_BANK_ACTIVE,
		SBR_BANK_PRECHARGING
	} sbr_bank_state_t;

	// Pins seen through the synchroniser
	typedef struct packed {
		logic ck;
		logic cs_b;
		logic ras_b;
		logic cas_b;
		logic we_b;
		logic [SBR_BA_W-1:0] ba;
		logic [SBR_ROW_W-1:0] addr;
		logic dll_locked;
		logic [1:0] mr0_burst;
		logic [SBR_LAT_W-1:0] al;
		logic [SBR_LAT_W-1:0] cl;
	} sbr_pins_t;

	// One accepted read, waiting for its latency
	typedef struct packed {
		logic [SBR_CYC_W-1:0] stamp;
		logic [SBR_BA_W-1:0] ba;
		logic [SBR_ROW_W-1:0] row;
		logic [SBR_COL_W-1:0] col;
		logic [3:0] beats;
		logic ap;
	} sbr_rd_t;
endpackage

// ---- sbr_bank_read.sv ----
// Contract
// - Activate opens given row in given bank
// - Row stays open until same-bank precharge
// - Precharge closes one bank or all
// - Activate only after precharge_period elapsed
// - Other banks usable during auto precharge
// - Precharge to idle/precharging bank is accepted
// - Precharge timed from latest precharge
// - Chop bit low gives four beats
// - Chop bit never used as column
// - Eight beats for field 00, 01+high
// - Burst choice same with auto precharge
// - AL 5, CL 6 gives eleven cycles
// - Read strobe timing only with DLL locked
// - One data beat per strobe edge
// - read_latency is additive plus column latency
`timescale 1ns/1ps
`default_nettype none

// Small synchronous FIFO with valid/ready on both sides
module sbr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	logic [WIDTH-1:0] mem_q [DEPTH]; // Storage
	logic [PW-1:0] wr_q; // Write pointer
	logic [PW-1:0] rd_q; // Read pointer
	logic [PW:0] cnt_q; // Occupancy
	logic push;
	logic pop;

	// Full and empty both come from the one occupancy count
	assign in_ready = (cnt_q != DEPTH[PW:0]);
	assign out_valid = (cnt_q != '0);
	assign out_data = mem_q[rd_q];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Storage has no reset; occupancy guards it
	always_ff @(posedge clk) begin
		if (push) begin
			mem_q[wr_q] <= in_data;
		end
	end

	// Pointers wrap at depth, which need not be a power of two
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end else begin
			if (push) begin
				wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
			end
			if (pop) begin
				rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
			end
			cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
		end
	end
endmodule // sbr_fifo

// Device side: bank tracking and read bursts with strobe
module sbr_bank_read
	import sbr_pkg::*;
#(
	parameter int PRECHARGE_CK = SBR_TRP_CK,
	parameter int FIFO_DEPTH = SBR_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic link_ck,
	input wire logic cs_b,
	input wire logic ras_b,
	input wire logic cas_b,
	input wire logic we_b,
	input wire logic [SBR_BA_W-1:0] bank_select_inputs,
	input wire logic [SBR_ROW_W-1:0] row_address_inputs,
	input wire logic dll_locked,
	input wire logic [1:0] mode_register_zero_burst,
	input wire logic [SBR_LAT_W-1:0] additive_latency,
	input wire logic [SBR_LAT_W-1:0] column_access_latency,
	output logic [7:0] dq_o,
	output logic dq_oe,
	output logic data_strobe_o,
	output logic data_strobe_oe,
	output logic [SBR_NUM_BANKS-1:0] bank_open,
	output logic cmd_error,
	output logic read_dropped
);
	localparam int RW = $bits(sbr_rd_t); // FIFO word width

	sbr_pins_t raw; // Pins gathered
	sbr_pins_t sync1_q; // First synchroniser stage
	sbr_pins_t sync2_q; // Second stage, safe to use
	logic ck_prev_q; // Last sampled link clock
	logic rise; // Link clock rising edge seen
	logic fall; // Link clock falling edge seen
	logic [SBR_CYC_W-1:0] lcyc_q; // Count of link rising edges
	logic is_act;
	logic is_pre;
	logic is_rd;
	logic [SBR_NUM_BANKS-1:0] act_hit;
	logic [SBR_NUM_BANKS-1:0] pre_hit;
	logic [SBR_NUM_BANKS-1:0] ap_hit;
	logic [SBR_NUM_BANKS-1:0] act_bad;
	logic [SBR_NUM_BANKS-1:0] pre_done; // Precharge period ends at this edge
	logic [SBR_NUM_BANKS-1:0] is_open;
	logic [SBR_ROW_W-1:0] open_row [SBR_NUM_BANKS];
	logic [3:0] req_beats; // Burst length of incoming read
	sbr_rd_t req; // Incoming read descriptor
	sbr_rd_t head; // Oldest pending read
	logic in_ready;
	logic out_valid;
	logic pop;
	logic rd_ok; // Read to an open bank
	logic [SBR_CYC_W-1:0] rl; // read_latency in link cycles
	logic [3:0] left_q; // Beats still to send
	logic [2:0] beat_q; // Beat index within burst
	logic [SBR_COL_W-1:0] bcol_q; // Column of burst
	logic [7:0] brow_q; // Low row bits of burst
	logic [SBR_BA_W-1:0] bba_q; // Bank of burst

	assign raw = '{ck: link_ck, cs_b: cs_b, ras_b: ras_b, cas_b: cas_b, we_b: we_b,
		ba: bank_select_inputs, addr: row_address_inputs, dll_locked: dll_locked,
		mr0_burst: mode_register_zero_burst, al: additive_latency,
		cl: column_access_latency};

	// Two flops on every pin; the first is read by the second only
	// A high link clock at release reads as one edge, decoded with the pins sampled alongside it
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sync1_q <= '{al: SBR_AL_RST, cl: SBR_CL_RST, cs_b: 1'b1, default: '0};
			sync2_q <= '{al: SBR_AL_RST, cl: SBR_CL_RST, cs_b: 1'b1, default: '0};
			ck_prev_q <= 1'b0;
		end else begin
			sync1_q <= raw;
			sync2_q <= sync1_q;
			ck_prev_q <= sync2_q.ck;
		end
	end

	// Edges show about three clk after the pin; pins must hold around them
	assign rise = sync2_q.ck && !ck_prev_q;
	assign fall = !sync2_q.ck && ck_prev_q;

	// Link cycle counter, stamps reads for their latency
	// Stamps wrap at 256; read_latency must stay far below that
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			lcyc_q <= '0;
		end else if (rise) begin
			lcyc_q <= lcyc_q + 1'b1;
		end
	end

	// Command decode on the link rising edge only
	assign is_act = rise && !sync2_q.cs_b && !sync2_q.ras_b && sync2_q.cas_b && sync2_q.we_b;
	assign is_pre = rise && !sync2_q.cs_b && !sync2_q.ras_b && sync2_q.cas_b && !sync2_q.we_b;
	assign is_rd = rise && !sync2_q.cs_b && sync2_q.ras_b && !sync2_q.cas_b && sync2_q.we_b;

	// Per-bank state machine and row register
	for (genvar b = 0; b < SBR_NUM_BANKS; b++) begin : g_bank
		sbr_bank_state_t st_q; // Bank state
		logic [SBR_ROW_W-1:0] row_q; // Open row number
		logic [SBR_TRP_W-1:0] trp_q; // precharge_period left

		assign act_hit[b] = is_act && (sync2_q.ba == SBR_BA_W'(b));
		// Period over at this link edge; an activate here is already legal
		assign pre_done[b] = rise && (st_q == SBR_BANK_PRECHARGING) &&
			(trp_q <= SBR_TRP_W'(1));
		// Single bank, or all banks with the all bit set
		assign pre_hit[b] = is_pre && (sync2_q.addr[SBR_AP_BIT] ||
			(sync2_q.ba == SBR_BA_W'(b)));
		assign ap_hit[b] = pop && head.ap && (head.ba == SBR_BA_W'(b));
		// Only an idle bank, or one on its closing precharge edge, takes an activate; early ones are refused
		assign act_bad[b] = act_hit[b] && (st_q != SBR_BANK_IDLE) && !pre_done[b];
		assign is_open[b] = (st_q == SBR_BANK_ACTIVE);
		assign open_row[b] = row_q;

		// Other banks keep their own state during auto precharge
		// A precharge outranks any activate to the same bank in one cycle
		always_ff @(posedge clk) begin
			if (!rst_b) begin
				st_q <= SBR_BANK_IDLE;
				row_q <= '0;
				trp_q <= '0;
			end else if (pre_hit[b] || ap_hit[b]) begin
				// Any state takes a precharge, counter restarts
				st_q <= SBR_BANK_PRECHARGING;
				trp_q <= SBR_TRP_W'(PRECHARGE_CK);
			end else begin
				case (st_q)
					SBR_BANK_IDLE: begin
						if (act_hit[b]) begin
							st_q <= SBR_BANK_ACTIVE;
							row_q <= sync2_q.addr;
						end
					end
					SBR_BANK_ACTIVE: begin
						// Reads leave the row open unless they carry auto precharge
						st_q <= SBR_BANK_ACTIVE; // Held until precharge
					end
					SBR_BANK_PRECHARGING: begin
						// Idle once the full period has run
						if (rise) begin
							if (pre_done[b]) begin
								// Activate on the closing edge is legal
								if (act_hit[b]) begin
									st_q <= SBR_BANK_ACTIVE;
									row_q <= sync2_q.addr;
								end else begin
									st_q <= SBR_BANK_IDLE;
								end
								trp_q <= '0;
							end else begin
								trp_q <= trp_q - 1'b1;
							end
						end
					end
					default: begin
						st_q <= SBR_BANK_IDLE;
					end
				endcase
			end
		end
	end

	// Burst length from the mode field and the chop bit
	always_comb begin
		case (sync2_q.mr0_burst)
			SBR_MR0_OTF: req_beats = sync2_q.addr[SBR_BC_BIT] ? SBR_BEATS_BL8 : SBR_BEATS_BC4;
			SBR_MR0_BC4: req_beats = SBR_BEATS_BC4;
			// The spare field code also gives eight beats
			default: req_beats = SBR_BEATS_BL8;
		endcase
	end

	// Only reads to an open bank are queued
	assign rd_ok = is_rd && is_open[sync2_q.ba];
	// Column from the low address bits; the chop bit is not among them
	assign req = '{stamp: lcyc_q, ba: sync2_q.ba, row: open_row[sync2_q.ba],
		col: sync2_q.addr[SBR_COL_W-1:0], beats: req_beats,
		ap: sync2_q.addr[SBR_AP_BIT]};

	// Pending reads; a full queue drops the read rather than stalling the link
	sbr_fifo #(
		.WIDTH(RW),
		.DEPTH(FIFO_DEPTH)
	) u_rd_fifo (
		.clk(clk),
		.rst_b(rst_b),
		.in_valid(rd_ok),
		.in_ready(in_ready),
		.in_data(req),
		.out_valid(out_valid),
		.out_ready(pop),
		.out_data(head)
	);

	// read_latency = additive + column latency
	assign rl = SBR_CYC_W'(sync2_q.al) + SBR_CYC_W'(sync2_q.cl);
	// Start on the rising edge that ends the latency, engine free; drains stall here
	assign pop = rise && out_valid && (left_q == '0) &&
		((lcyc_q - head.stamp) >= rl);

	// Burst engine, one beat per link edge
	// beat_q wraps to zero on the last beat of an eight-beat burst; every start reloads it
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			left_q <= '0;
			beat_q <= '0;
			bcol_q <= '0;
			brow_q <= '0;
			bba_q <= '0;
		end else if (pop) begin
			left_q <= head.beats - 1'b1;
			beat_q <= 3'h1;
			bcol_q <= head.col;
			brow_q <= head.row[7:0];
			bba_q <= head.ba;
		end else if ((rise || fall) && left_q != '0) begin
			left_q <= left_q - 1'b1;
			beat_q <= beat_q + 1'b1;
		end
	end

	// Pin drivers; the strobe is only driven while the DLL is locked
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dq_o <= '0;
			dq_oe <= 1'b0;
			data_strobe_o <= 1'b0;
			data_strobe_oe <= 1'b0;
		end else if (pop) begin
			dq_o <= head.col[7:0] ^ head.row[7:0];
			dq_oe <= sync2_q.dll_locked;
			data_strobe_o <= 1'b1; // Rising beat
			data_strobe_oe <= sync2_q.dll_locked;
		end else if (rise || fall) begin
			if (left_q != '0) begin
				dq_o <= (bcol_q[7:0] ^ brow_q) + {5'h00, beat_q} + {5'h00, bba_q};
				data_strobe_o <= rise; // High on rising beats, low on falling
				// A burst that lost the loop stays undriven to its end
				dq_oe <= dq_oe && sync2_q.dll_locked;
				data_strobe_oe <= data_strobe_oe && sync2_q.dll_locked;
			end else begin
				dq_oe <= 1'b0;
				data_strobe_oe <= 1'b0;
				data_strobe_o <= 1'b0;
			end
		end
	end

	// Status: open banks and one-cycle error pulses
	// Pulses, so a controller counting them sees each refusal once
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bank_open <= '0;
			cmd_error <= 1'b0;
			read_dropped <= 1'b0;
		end else begin
			bank_open <= is_open;
			// Activate to an open or still precharging bank, or read to a closed bank
			cmd_error <= (|act_bad) || (is_rd && !is_open[sync2_q.ba]);
			read_dropped <= rd_ok && !in_ready;
		end
	end
endmodule // sbr_bank_read

`default_nettype wire

// ---- sbr_bank_read_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
// Port checks on strobe, enables and bank flags
module sbr_bank_read_asserts
	import sbr_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic dll_locked,
	input wire logic dq_oe,
	input wire logic data_strobe_o,
	input wire logic data_strobe_oe,
	input wire logic [SBR_NUM_BANKS-1:0] bank_open,
	input wire logic cmd_error,
	input wire logic read_dropped
);
	logic [7:0] beat_q; // Beats in the current drive window
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	// One beat per strobe level; back-to-back bursts add up
	always_ff @(posedge clk) begin
		if (!rst_b || !data_strobe_oe) begin
			beat_q <= 8'h00;
		end else if (!$past(data_strobe_oe) || $changed(data_strobe_o)) begin
			beat_q <= beat_q + 8'h01;
		end
	end
	a_oe_paired: assert property (dq_oe == data_strobe_oe)
		else $error("data and strobe enables differ");
	a_first_high: assert property ($rose(data_strobe_oe) |-> data_strobe_o)
		else $error("burst did not open on a high strobe");
	a_half_cycle: assert property (data_strobe_oe && $changed(data_strobe_o)
		|=> $stable(data_strobe_o) [*3])
		else $error("strobe level shorter than half a link cycle");
	a_dll_gate: assert property (!dll_locked [*8] |-> !data_strobe_oe)
		else $error("strobe driven while loop unlocked");
	a_err_pulse: assert property (cmd_error |=> !cmd_error)
		else $error("refusal flag longer than one cycle");
	a_drop_pulse: assert property (read_dropped |=> !read_dropped)
		else $error("drop flag longer than one cycle");
	a_one_open: assert property ($countones(bank_open & ~$past(bank_open)) <= 1)
		else $error("several banks opened at once");
	a_burst_len: assert property ($fell(data_strobe_oe) && dll_locked |-> beat_q[1:0] == 2'h0)
		else $error("burst beat count not four or eight");
endmodule // sbr_bank_read_asserts
`default_nettype wire

// ---- sbr_ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// Controller: free link clock, command poster, beat catcher
module sbr_ctrl_model
	import sbr_pkg::*;
(
	input wire logic clk,
	output logic link_ck,
	output logic [3:0] pins,
	output logic [SBR_BA_W-1:0] ba,
	output logic [SBR_ROW_W-1:0] addr,
	input wire logic [7:0] dq_o,
	input wire logic dq_oe,
	input wire logic data_strobe_o,
	input wire logic cmd_error,
	input wire logic read_dropped
);
	int lk_n = 0; // Link rising edges
	int rd_at = 0; // Edge stamp of the last command
	int first_at = 0; // Edge stamp of the last burst start
	int errs = 0; // Refusals seen
	int drops = 0; // Dropped reads seen
	logic [7:0] beats[$]; // Captured beats
	logic oe_q = 1'b0; // Enable one clk ago
	logic st_q = 1'b0; // Strobe one clk ago
	// Odd offset keeps link edges off clk edges, at a fixed phase to clk
	initial begin
		link_ck = 1'b0;
		pins = 4'hF;
		ba = '0;
		addr = '0;
		#13;
		forever #200 link_ck = ~link_ck;
	end
	// Post across one rising edge, then deselect and scramble the address
	task automatic cmd(input logic [2:0] k, input logic [2:0] b, input logic [13:0] a);
		@(negedge link_ck);
		@(posedge clk);
		pins <= {1'b0, k};
		ba <= b;
		addr <= a;
		rd_at <= lk_n + 1;
		@(negedge link_ck);
		@(posedge clk);
		pins <= 4'hF;
		ba <= ~b;
		addr <= ~a;
	endtask
	always @(posedge link_ck) lk_n++;
	// One beat per strobe level while the device drives
	always @(posedge clk) begin
		if (dq_oe && !oe_q) first_at = lk_n;
		if (dq_oe && (!oe_q || data_strobe_o != st_q)) beats.push_back(dq_o);
		errs += int'(cmd_error);
		drops += int'(read_dropped);
		oe_q <= dq_oe;
		st_q <= data_strobe_o;
	end
endmodule // sbr_ctrl_model
`default_nettype wire

// ---- sbr_bank_read_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module sbr_bank_read_test;
	import sbr_pkg::*;
	localparam logic [2:0] cmd_act = 3'h3; // Row strobe only
	localparam logic [2:0] cmd_rd = 3'h5; // Column strobe only
	localparam logic [2:0] cmd_pre = 3'h2; // Row strobe and write
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic dll = 1'b1;
	logic [1:0] mrb = SBR_MR0_OTF;
	logic [SBR_LAT_W-1:0] al = SBR_AL_RST; // additive_latency driven
	int rl_exp = 11; // read_latency expected: additive plus column
	wire logic lk;
	wire logic [3:0] p;
	wire logic [2:0] ba;
	wire logic [13:0] ad;
	wire logic [7:0] dq;
	wire logic oe, st, err, drp;
	wire logic [7:0] bo;
	int error_cnt = 0;
	int tests_run = 0;
	always #25 clk = ~clk;
	// Short precharge period keeps the run brief
	sbr_bank_read #(.PRECHARGE_CK(3)) sbr_bank_read_i (.clk(clk), .rst_b(rst_b),
		.link_ck(lk), .cs_b(p[3]), .ras_b(p[2]), .cas_b(p[1]), .we_b(p[0]),
		.bank_select_inputs(ba), .row_address_inputs(ad), .dll_locked(dll),
		.mode_register_zero_burst(mrb), .additive_latency(al),
		.column_access_latency(SBR_CL_RST), .dq_o(dq), .dq_oe(oe), .data_strobe_o(st),
		.data_strobe_oe(), .bank_open(bo), .cmd_error(err), .read_dropped(drp));
	sbr_ctrl_model ctl (.clk(clk), .link_ck(lk), .pins(p), .ba(ba), .addr(ad), .dq_o(dq),
		.dq_oe(oe), .data_strobe_o(st), .cmd_error(err), .read_dropped(drp));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic lw(input int n);
		repeat (n) @(posedge lk);
	endtask
	// One read, judged on latency, length and beat values
	task automatic burst(input logic [2:0] b, input logic [7:0] r, input logic [13:0] a,
		input int n);
		logic [7:0] x;
		x = a[7:0] ^ r;
		ctl.beats.delete();
		ctl.cmd(cmd_rd, b, a);
		lw(16);
		chk(ctl.first_at - ctl.rd_at, rl_exp);
		chk(ctl.beats.size(), n);
		for (int k = 0; k < n; k++) chk(ctl.beats[k], k != 0 ? 8'(x + k + b) : x);
	endtask
	task automatic t_read;
		ctl.cmd(cmd_act, 3'h2, 14'h1234);
		lw(2);
		chk(bo, 8'h04);
		burst(3'h2, 8'h34, 14'h1021, 8);
		burst(3'h2, 8'h34, 14'h0021, 4);
		burst(3'h2, 8'h34, 14'h0421, 4);
		chk(bo, 8'h00);
	endtask
	// Every burst field, chop bit held low
	task automatic t_modes;
		ctl.cmd(cmd_act, 3'h5, 14'h0077);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk) mrb <= 2'(i);
			burst(3'h5, 8'h77, 14'h0003, (i == 1 || i == 2) ? 4 : 8);
		end
		@(posedge clk) mrb <= SBR_MR0_OTF;
		// No additive latency: read_latency is the column latency alone
		@(posedge clk) al <= 4'h0;
		rl_exp = 6;
		burst(3'h5, 8'h77, 14'h1003, 8);
		@(posedge clk) al <= SBR_AL_RST;
		rl_exp = 11;
	endtask
	task automatic t_pre;
		int e;
		e = ctl.errs;
		ctl.cmd(cmd_act, 3'h1, 14'h0100);
		ctl.cmd(cmd_pre, 3'h1, 14'h0000);
		ctl.cmd(cmd_pre, 3'h1, 14'h0000);
		ctl.cmd(cmd_act, 3'h1, 14'h0100);
		ctl.cmd(cmd_pre, 3'h6, 14'h0000);
		lw(4);
		ctl.cmd(cmd_act, 3'h1, 14'h0200);
		ctl.cmd(cmd_act, 3'h6, 14'h0300);
		ctl.cmd(cmd_rd, 3'h0, 14'h0000);
		lw(2);
		chk(ctl.errs - e, 2);
		chk(bo, 8'h62);
		ctl.cmd(cmd_pre, 3'h0, 14'h0400);
		lw(2);
		chk(bo, 8'h00);
	endtask
	// Unlocked loop: reads run but nothing is driven
	task automatic t_dll;
		int e;
		e = ctl.errs;
		@(posedge clk) dll <= 1'b0;
		// Lands exactly one precharge_period after the precharge-all
		ctl.cmd(cmd_act, 3'h3, 14'h0000);
		ctl.beats.delete();
		ctl.cmd(cmd_rd, 3'h3, 14'h1000);
		lw(16);
		chk(ctl.beats.size(), 0);
		chk(ctl.errs - e, 0);
		chk(bo, 8'h08);
		@(posedge clk) dll <= 1'b1;
	endtask
	// Five queued reads: the fifth finds the queue full
	task automatic t_fifo;
		int d;
		d = ctl.drops;
		ctl.beats.delete();
		repeat (5) ctl.cmd(cmd_rd, 3'h3, 14'h1000);
		lw(40);
		chk(ctl.drops - d, 1);
		chk(ctl.beats.size(), 32);
	endtask
	task automatic final_report;
		$display("errors %0d checks %0d", error_cnt, tests_run);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		lw(4);
		t_read;
		t_modes;
		t_pre;
		t_dll;
		t_fifo;
		final_report;
	end
	// Watchdog well past the expected run
	initial begin
		#400000;
		error_cnt++;
		final_report;
	end
endmodule // sbr_bank_read_test
bind sbr_bank_read sbr_bank_read_asserts sbr_bank_read_asserts_i (.clk(clk), .rst_b(rst_b),
	.dll_locked(dll_locked), .dq_oe(dq_oe), .data_strobe_o(data_strobe_o),
	.data_strobe_oe(data_strobe_oe), .bank_open(bank_open), .cmd_error(cmd_error),
	.read_dropped(read_dropped));
`default_nettype wire
